/* eim_pkg.sv */
package eim_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices and address width
  localparam logic [7:0]  EIM_IDX_VEC0    = 8'h7C;
  localparam logic [7:0]  EIM_IDX_VEC1    = 8'h7D;
  localparam logic [7:0]  EIM_IDX_VEC2    = 8'h7E;
  localparam logic [7:0]  EIM_IDX_VEC3    = 8'h7F;
  localparam logic [7:0]  EIM_IDX_MODE    = 8'h70;
  localparam logic [7:0]  EIM_IDX_STATUS  = 8'h71;
  localparam logic [7:0]  EIM_IDX_MASK    = 8'h72;
  localparam int          EIM_ADDR_W      = 12;

  ////////////////////////////////////////////////////////////////////////////
  // Mode register fields and reset values
  localparam int          EIM_MODE_NMI_BOTH = 0;
  localparam int          EIM_MODE_I0_LEVEL = 1;
  localparam int          EIM_MODE_I0_EN    = 2;
  localparam logic [7:0]  EIM_MODE_RO_ONES  = 8'hF8;
  localparam logic [2:0]  EIM_MODE_RESET    = 3'h0;
  localparam logic [5:0]  EIM_VEC_RESET     = 6'h00;
  localparam int          EIM_VEC_W         = 6;
  localparam int          EIM_NCH           = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Status bit positions
  localparam int          EIM_ST_NMI   = 0;
  localparam int          EIM_ST_IRQ0  = 1;
  localparam int          EIM_ST_IRQ4  = 2;
  localparam int          EIM_ST_IRQ5  = 3;
  localparam int          EIM_ST_IRQ6  = 4;
  localparam int          EIM_ST_IRQ7  = 5;
  localparam int          EIM_ST_CONV  = 6;
  localparam int          EIM_ST_RX    = 7;
  localparam logic [7:0]  EIM_ST_LEVEL = 8'hC0;
  localparam logic [7:0]  EIM_ST_RESET = 8'h00;
  localparam logic [7:0]  EIM_MASK_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Capture mode that selects a falling edge, bus responses
  localparam logic [1:0]  EIM_CAP_FALL = 2'h2;
  localparam logic [1:0]  EIM_RESP_OK  = 2'h0;
  localparam logic [1:0]  EIM_RESP_ERR = 2'h2;
  localparam int          EIM_NPINS    = 6;

  // External pins, in package order
  typedef struct packed {
    logic nmi;
    logic ext_irq_zero;
    logic ext_irq_four;
    logic ext_irq_five;
    logic ext_irq_six;
    logic ext_irq_seven;
  } eim_pins_t;

  // Result of a vector comparison
  typedef struct packed {
    logic       hit;
    logic [1:0] chan;
  } eim_dma_res_t;

endpackage

/* eim_pin_sync.sv */
module eim_pin_sync import eim_pkg::*; #(
  parameter int WIDTH = EIM_NPINS
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] next_level;
  logic [3:0]       fill;
  logic [3:0]       next_fill;

  ////////////////////////////////////////////////////////////////////////////
  // Filtered level changes once the second and third stages agree;
  // edges wait until the stages hold real pin values, so an idle-high
  // pin gives no false edge after reset
  always_comb begin
    next_level = level;
    next_fill  = {fill[2:0], 1'b1};
    for (int i = 0; i < WIDTH; i++) begin
      if (s2[i] == s3[i]) begin
        next_level[i] = s3[i];
      end
    end
  end

  // Three stage synchroniser and filtered level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1    <= '0;
      s2    <= '0;
      s3    <= '0;
      level <= '0;
      fill  <= 4'h0;
    end else begin
      s1    <= pin_in;
      s2    <= s1;
      s3    <= s2;
      level <= next_level;
      fill  <= next_fill;
    end
  end

  // Edges from current against previous filtered value
  assign rise = fill[3] ? (next_level & ~level) : '0;
  assign fall = fill[3] ? (~next_level & level) : '0;

endmodule // eim_pin_sync

/* eim_dma_match.sv */
module eim_dma_match import eim_pkg::*; #(
  parameter int NCH = EIM_NCH
) (
  input  wire logic [NCH-1:0][EIM_VEC_W-1:0] start_vec,
  input  wire logic [7:0]                    vector,
  output eim_dma_res_t                       res
);

  ////////////////////////////////////////////////////////////////////////////
  // Scan from the top so the lowest matching channel wins
  always_comb begin
    res = '0;
    for (int c = NCH - 1; c >= 0; c--) begin
      if (start_vec[c] == vector[7:2]) begin
        res.hit  = 1'b1;
        res.chan = 2'(c);
      end
    end
  end

endmodule // eim_dma_match

/* eim_ext_irq.sv */
// Register access over AXI4-Lite was decided locally.
module eim_ext_irq import eim_pkg::*; (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite slave
  input  wire logic [EIM_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [EIM_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // External pins
  input  wire eim_pins_t             ext_pins,
  // Timer capture modes, same clock
  input  wire logic [1:0]            timer_a_capture_mode,
  input  wire logic [1:0]            timer_b_capture_mode,
  // Level sources and their clearing reads
  input  wire logic                  converter_done_irq,
  input  wire logic                  conv_value_read,
  input  wire logic                  serial_rx_irq,
  input  wire logic                  rx_buffer_read,
  // Standby and shared pin use
  input  wire logic                  standby,
  output logic                       irq0_shared_pin_is_port,
  output logic                       irq0_standby_wake,
  // CPU vector read
  input  wire logic                  vec_read,
  input  wire logic [7:0]            vec_value,
  output logic                       udma_service,
  output logic                       normal_service,
  output logic [1:0]                 udma_channel,
  // Interrupt line
  output logic                       irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode helpers

  // Register index of an aligned byte address
  function automatic logic [7:0] reg_index(input logic [EIM_ADDR_W-1:0] a);
    reg_index = a[9:2];
  endfunction

  // True when an address lands on a known register
  function automatic logic mapped(input logic [EIM_ADDR_W-1:0] a);
    logic [7:0] i;
    i = reg_index(a);
    mapped = (a[EIM_ADDR_W-1:10] == '0) &&
             ((i == EIM_IDX_MODE) || (i == EIM_IDX_STATUS) ||
              (i == EIM_IDX_MASK) || (i[7:2] == EIM_IDX_VEC0[7:2]));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [2:0]                            mode;
  logic [7:0]                            status;
  logic [7:0]                            mask;
  logic [EIM_NCH-1:0][EIM_VEC_W-1:0]     start_vec;
  logic [2:0]                            next_mode;
  logic [7:0]                            next_status;
  logic [7:0]                            next_mask;
  logic [EIM_NCH-1:0][EIM_VEC_W-1:0]     next_start_vec;

  logic                                  aw_held;
  logic                                  w_held;
  logic [EIM_ADDR_W-1:0]                 aw_addr;
  logic [7:0]                            w_byte;
  logic                                  w_lane0;
  logic                                  next_aw_held;
  logic                                  next_w_held;
  logic [EIM_ADDR_W-1:0]                 next_aw_addr;
  logic [7:0]                            next_w_byte;
  logic                                  next_w_lane0;
  logic                                  next_bvalid;
  logic [1:0]                            next_bresp;
  logic                                  next_rvalid;
  logic [1:0]                            next_rresp;
  logic [31:0]                           next_rdata;
  logic                                  wr_do;
  logic [7:0]                            wr_idx;
  logic [7:0]                            rd_idx;

  logic [EIM_NPINS-1:0]                  pin_lvl;
  logic [EIM_NPINS-1:0]                  pin_rise;
  logic [EIM_NPINS-1:0]                  pin_fall;
  eim_pins_t                             lvl;
  eim_pins_t                             rise;
  eim_pins_t                             fall;
  logic [7:0]                            set_ev;
  logic [7:0]                            clr_ev;

  eim_dma_res_t                          match;
  logic                                  next_udma_service;
  logic                                  next_normal_service;
  logic [1:0]                            next_udma_channel;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection

  eim_pin_sync #(
    .WIDTH (EIM_NPINS)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (ext_pins),
    .level   (pin_lvl),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  // View the vectors as pin structs
  assign lvl  = eim_pins_t'(pin_lvl);
  assign rise = eim_pins_t'(pin_rise);
  assign fall = eim_pins_t'(pin_fall);

  ////////////////////////////////////////////////////////////////////////////
  // Event sources per status bit
  always_comb begin
    set_ev = '0;
    // Falling edge, plus rising edge when both edges selected
    set_ev[EIM_ST_NMI]  = fall.nmi |
                          (mode[EIM_MODE_NMI_BOTH] & rise.nmi);
    // Level or rising edge, only when the input is enabled
    if (mode[EIM_MODE_I0_EN]) begin
      set_ev[EIM_ST_IRQ0] = mode[EIM_MODE_I0_LEVEL] ?
                            lvl.ext_irq_zero : rise.ext_irq_zero;
    end
    set_ev[EIM_ST_IRQ4] = (timer_a_capture_mode == EIM_CAP_FALL) ?
                          fall.ext_irq_four : rise.ext_irq_four;
    set_ev[EIM_ST_IRQ6] = (timer_b_capture_mode == EIM_CAP_FALL) ?
                          fall.ext_irq_six : rise.ext_irq_six;
    set_ev[EIM_ST_IRQ5] = rise.ext_irq_five;
    set_ev[EIM_ST_IRQ7] = rise.ext_irq_seven;
    set_ev[EIM_ST_CONV] = converter_done_irq;
    set_ev[EIM_ST_RX]   = serial_rx_irq;
  end

  // Shared pin stays a port pin unless the input is enabled
  assign irq0_shared_pin_is_port = ~mode[EIM_MODE_I0_EN];
  assign irq0_standby_wake = standby & mode[EIM_MODE_I0_EN] &
                             lvl.ext_irq_zero;

  ////////////////////////////////////////////////////////////////////////////
  // AXI write channel: address and data taken in either order
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign wr_do         = aw_held & w_held & ~s_axi_bvalid;
  assign wr_idx        = reg_index(aw_addr);

  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_byte  = w_byte;
    next_w_lane0 = w_lane0;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held  = 1'b1;
      next_w_byte  = s_axi_wdata[7:0];
      next_w_lane0 = s_axi_wstrb[0];
    end
    if (wr_do) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = mapped(aw_addr) ? EIM_RESP_OK : EIM_RESP_ERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid  = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= '0;
      w_byte       <= 8'h00;
      w_lane0      <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= EIM_RESP_OK;
    end else begin
      aw_held      <= next_aw_held;
      w_held       <= next_w_held;
      aw_addr      <= next_aw_addr;
      w_byte       <= next_w_byte;
      w_lane0      <= next_w_lane0;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file; only byte lane 0 holds data
  always_comb begin
    next_mode      = mode;
    next_mask      = mask;
    next_start_vec = start_vec;
    clr_ev         = '0;
    if (wr_do && w_lane0) begin
      if (wr_idx == EIM_IDX_MODE) begin
        next_mode = w_byte[2:0];
      end else if (wr_idx == EIM_IDX_MASK) begin
        next_mask = w_byte;
      end else if (wr_idx == EIM_IDX_STATUS) begin
        // Level sources are left alone by a software clear
        clr_ev = w_byte & ~EIM_ST_LEVEL;
      end else if (wr_idx[7:2] == EIM_IDX_VEC0[7:2]) begin
        next_start_vec[wr_idx[1:0]] = w_byte[EIM_VEC_W-1:0];
      end
    end
    // Level flags clear only on the data read of their source
    clr_ev[EIM_ST_CONV] = conv_value_read;
    clr_ev[EIM_ST_RX]   = rx_buffer_read;
    // Clear may coincide with a new event; a new set still wins
    next_status = (status & ~clr_ev) | set_ev;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode      <= EIM_MODE_RESET;
      status    <= EIM_ST_RESET;
      mask      <= EIM_MASK_RESET;
      start_vec <= {EIM_NCH{EIM_VEC_RESET}};
    end else begin
      mode      <= next_mode;
      status    <= next_status;
      mask      <= next_mask;
      start_vec <= next_start_vec;
    end
  end

  // Interrupt line high while an unmasked flag is set
  assign irq = |(status & mask);

  ////////////////////////////////////////////////////////////////////////////
  // AXI read channel
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_idx        = reg_index(s_axi_araddr);

  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rresp  = s_axi_rresp;
    next_rdata  = s_axi_rdata;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = mapped(s_axi_araddr) ? EIM_RESP_OK : EIM_RESP_ERR;
      next_rdata  = 32'h0000_0000;
      if (!mapped(s_axi_araddr)) begin
        next_rdata = 32'h0000_0000;
      end else if (rd_idx == EIM_IDX_MODE) begin
        next_rdata[7:0] = EIM_MODE_RO_ONES | {5'h00, mode};
      end else if (rd_idx == EIM_IDX_STATUS) begin
        next_rdata[7:0] = status;
      end else if (rd_idx == EIM_IDX_MASK) begin
        next_rdata[7:0] = mask;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= EIM_RESP_OK;
      s_axi_rdata  <= 32'h0000_0000;
    end else begin
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp  <= next_rresp;
      s_axi_rdata  <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Vector comparison against the start vectors

  eim_dma_match #(
    .NCH (EIM_NCH)
  ) u_match (
    .start_vec (start_vec),
    .vector    (vec_value),
    .res       (match)
  );

  // Service decision registered one cycle after the vector read
  always_comb begin
    next_udma_service   = 1'b0;
    next_normal_service = 1'b0;
    next_udma_channel   = udma_channel;
    if (vec_read) begin
      next_udma_service   = match.hit;
      next_normal_service = ~match.hit;
      if (match.hit) begin
        next_udma_channel = match.chan;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      udma_service   <= 1'b0;
      normal_service <= 1'b0;
      udma_channel   <= 2'h0;
    end else begin
      udma_service   <= next_udma_service;
      normal_service <= next_normal_service;
      udma_channel   <= next_udma_channel;
    end
  end

endmodule // eim_ext_irq

/* eim_ext_irq_asserts.sv */
module eim_ext_irq_asserts import eim_pkg::*; (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic [EIM_ADDR_W-1:0] s_axi_araddr,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic [1:0]            s_axi_rresp,
  input wire logic                  s_axi_rvalid,
  input wire logic                  standby,
  input wire logic                  irq0_shared_pin_is_port,
  input wire logic                  irq0_standby_wake,
  input wire logic                  vec_read,
  input wire logic                  udma_service,
  input wire logic                  normal_service,
  input wire logic [1:0]            udma_channel
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] MODE_A = {2'h0, EIM_IDX_MODE, 2'h0};
  logic [EIM_ADDR_W-1:0] rd_addr;
  logic [EIM_ADDR_W-1:0] next_rd_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Address of the read under way
  always_comb begin
    next_rd_addr = rd_addr;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rd_addr = s_axi_araddr;
    end
  end

  always_ff @(posedge aclk) begin
    rd_addr <= next_rd_addr;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_vec_taken;
    vec_read;
  endsequence

  sequence s_one_answer;
    udma_service ^ normal_service;
  endsequence

  a_svc_one_hot: assert property (
    s_vec_taken |=> s_one_answer) else $error("no single service answer");
  a_svc_idle: assert property (
    !vec_read |=> !udma_service && !normal_service)
    else $error("service without vector read");
  a_chan_hold: assert property (
    !vec_read |=> $stable(udma_channel)) else $error("channel moved");
  a_mode_ones: assert property (
    s_axi_rvalid && rd_addr == MODE_A |-> s_axi_rdata[7:3] == 5'h1F)
    else $error("mode upper bits not one");
  a_mode_resp: assert property (
    s_axi_rvalid && rd_addr == MODE_A |-> s_axi_rresp == EIM_RESP_OK)
    else $error("mode read refused");
  a_vec_zero: assert property (
    s_axi_rvalid && rd_addr[11:4] == 8'h1F |-> s_axi_rdata == 32'h0)
    else $error("vector register readable");
  a_wake_standby: assert property (
    irq0_standby_wake |-> standby) else $error("wake outside standby");
  a_wake_port: assert property (
    irq0_standby_wake |-> !irq0_shared_pin_is_port)
    else $error("wake while pin is port");
endmodule // eim_ext_irq_asserts

bind eim_ext_irq eim_ext_irq_asserts i_chk (.aclk, .aresetn, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .standby, .irq0_shared_pin_is_port, .irq0_standby_wake, .vec_read,
  .udma_service, .normal_service, .udma_channel);

/* eim_cpu_model.sv */
module eim_cpu_model import eim_pkg::*; (
  input  wire logic aclk,
  output logic      vec_read,
  output logic [7:0] vec_value
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus carries no stale vector; no mask level restore is modelled
  initial begin
    vec_read = 1'b0;
    vec_value = 8'hA5;
  end

  // One vector read of an accepted interrupt, then the bus is released
  task automatic fetch(input logic [7:0] v);
    @(posedge aclk);
    vec_read <= 1'b1;
    vec_value <= v;
    @(posedge aclk);
    vec_read <= 1'b0;
    vec_value <= ~v;
  endtask
endmodule // eim_cpu_model

/* test_ext_irq_mode_and_dma_vector_match.sv */
module test_ext_irq_mode_and_dma_vector_match import eim_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0, aresetn = 1'b0, standby = 1'b0, irq;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
  logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, udma_channel, r;
  logic [1:0] timer_a_capture_mode = 2'h0, timer_b_capture_mode = 2'h0;
  logic converter_done_irq = 1'b0, conv_value_read = 1'b0;
  logic serial_rx_irq = 1'b0, rx_buffer_read = 1'b0, vec_read;
  logic irq0_shared_pin_is_port, irq0_standby_wake, udma_service;
  logic normal_service;
  logic [7:0] vec_value;
  logic [31:0] d;
  logic [7:0] mk = 8'hFF;
  eim_pins_t pins = '0;
  int miscompares = 0;
  int total_checks = 0;
  logic [7:0] vv [5] = '{8'h40, 8'h43, 8'h88, 8'hFC, 8'h04};
  logic [1:0] vc [5] = '{2'h1, 2'h1, 2'h3, 2'h0, 2'h0};

  always #20 aclk = ~aclk;

  eim_cpu_model i_cpu (.aclk, .vec_read, .vec_value);
  eim_ext_irq i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ext_pins(pins), .timer_a_capture_mode, .timer_b_capture_mode,
    .converter_done_irq, .conv_value_read, .serial_rx_irq, .rx_buffer_read,
    .standby, .irq0_shared_pin_is_port, .irq0_standby_wake, .vec_read,
    .vec_value, .udma_service, .normal_service, .udma_channel, .irq);

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, comparison and bus tasks
  task automatic stop_test;
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  function automatic logic [11:0] ra(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction

  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
    if (n == 50) begin
      cmp(32'h0, 32'h1);
      stop_test();
    end
  endtask

  task automatic rd(input logic [11:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (n == 50) begin
      cmp(32'h0, 32'h1);
      stop_test();
    end
  endtask

  // Move one pin from v0 to its inverse and look for the flag
  task automatic edge_case(input int p, input logic v0, input logic exp);
    pins[p] <= v0;
    cyc(8);
    wr(ra(EIM_IDX_STATUS), 8'hFF);
    pins[p] <= ~v0;
    cyc(8);
    rd(ra(EIM_IDX_STATUS));
    cmp(d, exp ? 32'(8'h01 << (5 - p)) : 32'h0);
    cmp(32'(irq), 32'(exp & mk[5 - p]));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    cyc(12);
    aresetn <= 1'b1;
    rd(ra(EIM_IDX_MODE));
    cmp(d, 32'hF8);
    for (int i = 0; i < 4; i++) begin
      rd(ra(EIM_IDX_VEC0 + 8'(i)));
      cmp({d[31:2], r}, 32'h0);
    end
    rd(12'h000);
    cmp(32'(r), 32'(EIM_RESP_ERR));
    wr(12'h004, 8'hFF);
    cmp(32'(r), 32'(EIM_RESP_ERR));
    i_cpu.fetch(8'h03);
    #1 cmp({udma_service, udma_channel}, 32'h4);
    wr(ra(EIM_IDX_MASK), 8'hFF);
    wr(ra(EIM_IDX_MODE), 8'h05);
    rd(ra(EIM_IDX_MODE));
    cmp(d, 32'hFD);
    edge_case(5, 1'b0, 1'b1);
    edge_case(5, 1'b1, 1'b1);
    wr(ra(EIM_IDX_MODE), 8'h04);
    edge_case(5, 1'b1, 1'b1);
    edge_case(5, 1'b0, 1'b0);
    edge_case(4, 1'b0, 1'b1);
    edge_case(4, 1'b1, 1'b0);
    for (int m = 0; m < 4; m++) begin
      timer_a_capture_mode <= 2'(m);
      timer_b_capture_mode <= 2'(m);
      edge_case(3, 1'b0, m != 2);
      edge_case(3, 1'b1, m == 2);
      edge_case(1, 1'b0, m != 2);
      edge_case(1, 1'b1, m == 2);
    end
    edge_case(2, 1'b0, 1'b1);
    edge_case(0, 1'b1, 1'b0);
    edge_case(0, 1'b0, 1'b1);
    mk = 8'hF7;
    wr(ra(EIM_IDX_MASK), mk);
    edge_case(2, 1'b0, 1'b1);
    mk = 8'hFF;
    wr(ra(EIM_IDX_MASK), mk);
    cmp(32'(irq), 32'h1);
    for (int s = 0; s < 2; s++) begin
      converter_done_irq <= (s == 0);
      serial_rx_irq <= (s == 1);
      cyc(1);
      converter_done_irq <= 1'b0;
      serial_rx_irq <= 1'b0;
      wr(ra(EIM_IDX_STATUS), 8'hFF);
      rd(ra(EIM_IDX_STATUS));
      cmp(d, (s == 0) ? 32'h40 : 32'h80);
      conv_value_read <= (s == 0);
      rx_buffer_read <= (s == 1);
      cyc(1);
      conv_value_read <= 1'b0;
      rx_buffer_read <= 1'b0;
      rd(ra(EIM_IDX_STATUS));
      cmp(d, 32'h0);
    end
    cmp(32'(irq0_shared_pin_is_port), 32'h0);
    wr(ra(EIM_IDX_MODE), 8'h06);
    pins.ext_irq_zero <= 1'b1;
    standby <= 1'b1;
    cyc(8);
    cmp(32'(irq0_standby_wake), 32'h1);
    wr(ra(EIM_IDX_STATUS), 8'hFF);
    rd(ra(EIM_IDX_STATUS));
    cmp(d, 32'h02);
    pins.ext_irq_zero <= 1'b0;
    cyc(8);
    wr(ra(EIM_IDX_MASK), 8'hFD);
    wr(ra(EIM_IDX_STATUS), 8'h02);
    wr(ra(EIM_IDX_MODE), 8'h04);
    wr(ra(EIM_IDX_MASK), 8'hFF);
    rd(ra(EIM_IDX_STATUS));
    cmp(d, 32'h0);
    wr(ra(EIM_IDX_MODE), 8'h00);
    pins.ext_irq_zero <= 1'b1;
    cyc(8);
    cmp({irq0_shared_pin_is_port, irq0_standby_wake}, 32'h2);
    standby <= 1'b0;
    wr(ra(EIM_IDX_VEC0), 8'h3F);
    wr(ra(EIM_IDX_VEC1), 8'h10);
    wr(ra(EIM_IDX_VEC2), 8'h10);
    wr(ra(EIM_IDX_VEC3), 8'hE2);
    for (int i = 0; i < 5; i++) begin
      i_cpu.fetch(vv[i]);
      #1 cmp({udma_service, normal_service}, (i < 4) ? 32'h2 : 32'h1);
      if (i < 4) cmp(32'(udma_channel), 32'(vc[i]));
    end
    stop_test();
  end
endmodule // test_ext_irq_mode_and_dma_vector_match
